/* core/tswdt_pkg.sv */
// Purpose: Constants shared by the two-stage watchdog timer.
// Assumes: 32-bit register bus, byte addresses.
// Notes: Offsets are word aligned.
package tswdt_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_LOAD = 8'h00;
  localparam logic [7:0] ADDR_VALUE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_MSTAT = 8'h14;
  localparam logic [7:0] ADDR_LOCK = 8'h18;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_RSTEN = 1;
  localparam int CTRL_NMI = 2;
  localparam int STAT_W = 2;
  localparam int ST_FIRST = 0;
  localparam int ST_SECOND = 1;
  localparam logic [31:0] LOAD_RST = 32'hFFFF_FFFF;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h3;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // Unlock key; the value is arbitrary.
  localparam logic [31:0] UNLOCK_KEY = 32'h5A5A_0001;
endpackage : tswdt_pkg

/* core/tswdt_sticky.sv */
// Purpose: Sticky status bits, set by events, cleared by writing one.
// Assumes: Set and clear come from the same clock.
// Notes: A set in the cycle of a clear wins.
`timescale 1ns/100ps
`default_nettype none
module tswdt_sticky #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;

  // ---------------------------------------------------------------
  // Flag update
  // ---------------------------------------------------------------
  always_comb begin
    nxt_flags = (flags_ff & ~clr) | set;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;
endmodule : tswdt_sticky
`default_nettype wire

/* core/tswdt_top.sv */
// Purpose: Two-stage watchdog with interrupt, reset output and lock.
// Assumes: One 200 MHz clock, synchronous active-high reset.
// Notes: Enable is sticky until reset; the lock guards configuration.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - 32-bit down counter, load, interrupt, lock
// - Zero after enable raises first timeout interrupt
// - Enabling counter also enables the interrupt
// - First timeout reloads counter from load value
// - Second zero while pending asserts reset
// - Clearing pending interrupt reloads the counter
// - Load write while running loads counter immediately
// - Lock blocks configuration changes
// - Enable attempt while locked does nothing
// - Interrupt clear drops the interrupt output
// - Interrupt type selectable: standard or non-maskable
// - Load of zero interrupts immediately
// - Raw and masked status readable, one active
// - Lock state readable by software
module tswdt_top #(
  parameter int CNT_W = 32
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  output logic nmi,
  output logic sys_rst_out
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] load_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic run_ff;
  logic rsten_ff;
  logic nmisel_ff;
  logic lock_ff;
  logic sysrst_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [tswdt_pkg::STAT_W-1:0] mask_ff;
  logic [tswdt_pkg::STAT_W-1:0] stat;
  logic [tswdt_pkg::STAT_W-1:0] st_set;
  logic [tswdt_pkg::STAT_W-1:0] st_clr;
  logic [tswdt_pkg::STAT_W-1:0] mstat;
  logic cfg_ok;
  logic wr_load;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_stat;
  logic wr_lock;
  logic en_start;
  logic tmo_ev;
  logic first_ev;
  logic second_ev;
  logic clr_first;
  logic int_act;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  assign cfg_ok = !lock_ff;
  assign wr_load = wr_en && (addr == tswdt_pkg::ADDR_LOAD) && cfg_ok;
  assign wr_ctrl = wr_en && (addr == tswdt_pkg::ADDR_CTRL) && cfg_ok;
  assign wr_mask = wr_en && (addr == tswdt_pkg::ADDR_MASK) && cfg_ok;
  assign wr_stat = wr_en && (addr == tswdt_pkg::ADDR_STAT);
  assign wr_lock = wr_en && (addr == tswdt_pkg::ADDR_LOCK);
  assign en_start = wr_ctrl && wdata[tswdt_pkg::CTRL_EN] && !run_ff;

  // ---------------------------------------------------------------
  // Timeout events
  // ---------------------------------------------------------------
  assign tmo_ev = run_ff && (cnt_ff == '0);
  assign first_ev = tmo_ev && !stat[tswdt_pkg::ST_FIRST];
  assign second_ev = tmo_ev && stat[tswdt_pkg::ST_FIRST];
  assign clr_first = wr_stat && wdata[tswdt_pkg::ST_FIRST]
    && stat[tswdt_pkg::ST_FIRST];

  always_comb begin
    st_set = '0;
    st_set[tswdt_pkg::ST_FIRST] = first_ev;
    st_set[tswdt_pkg::ST_SECOND] = second_ev;
    st_clr = wr_stat ? wdata[tswdt_pkg::STAT_W-1:0] : '0;
  end

  tswdt_sticky #(
    .WIDTH(tswdt_pkg::STAT_W)
  ) u_status (
    .clock(clock),
    .srst(srst),
    .set(st_set),
    .clr(st_clr),
    .flags(stat)
  );

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      load_ff <= tswdt_pkg::LOAD_RST[CNT_W-1:0];
    end else if (wr_load) begin
      load_ff <= wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      run_ff <= 1'b0;
      rsten_ff <= 1'b0;
      nmisel_ff <= 1'b0;
    end else if (wr_ctrl) begin
      run_ff <= run_ff | wdata[tswdt_pkg::CTRL_EN];
      rsten_ff <= wdata[tswdt_pkg::CTRL_RSTEN];
      nmisel_ff <= wdata[tswdt_pkg::CTRL_NMI];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mask_ff <= tswdt_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= wdata[tswdt_pkg::STAT_W-1:0];
    end
  end

  // Any write other than the key locks; the key unlocks.
  always_ff @(posedge clock) begin
    if (srst) begin
      lock_ff <= 1'b0;
    end else if (wr_lock) begin
      lock_ff <= (wdata != tswdt_pkg::UNLOCK_KEY);
    end
  end

  // ---------------------------------------------------------------
  // Down counter
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    if (wr_load && run_ff) begin
      nxt_cnt = wdata[CNT_W-1:0];
    end else if (en_start) begin
      nxt_cnt = load_ff;
    end else if (clr_first && run_ff) begin
      nxt_cnt = load_ff;
    end else if (tmo_ev) begin
      nxt_cnt = load_ff;
    end else if (run_ff) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_ff <= tswdt_pkg::LOAD_RST[CNT_W-1:0];
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Reset output, held until the system reset
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      sysrst_ff <= 1'b0;
    end else if (second_ev && rsten_ff) begin
      sysrst_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt outputs
  // ---------------------------------------------------------------
  assign mstat = stat & mask_ff & {tswdt_pkg::STAT_W{run_ff}};
  assign int_act = |mstat;
  assign irq = int_act && !nmisel_ff;
  assign nmi = int_act && nmisel_ff;
  assign sys_rst_out = sysrst_ff;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = tswdt_pkg::DATA_ZERO;
    if (rd_en) begin
      unique case (addr)
        tswdt_pkg::ADDR_LOAD: nxt_rdata[CNT_W-1:0] = load_ff;
        tswdt_pkg::ADDR_VALUE: nxt_rdata[CNT_W-1:0] = cnt_ff;
        tswdt_pkg::ADDR_CTRL: begin
          nxt_rdata[tswdt_pkg::CTRL_EN] = run_ff;
          nxt_rdata[tswdt_pkg::CTRL_RSTEN] = rsten_ff;
          nxt_rdata[tswdt_pkg::CTRL_NMI] = nmisel_ff;
        end
        tswdt_pkg::ADDR_STAT: nxt_rdata[tswdt_pkg::STAT_W-1:0] = stat;
        tswdt_pkg::ADDR_MASK: nxt_rdata[tswdt_pkg::STAT_W-1:0] = mask_ff;
        tswdt_pkg::ADDR_MSTAT: nxt_rdata[tswdt_pkg::STAT_W-1:0] = mstat;
        tswdt_pkg::ADDR_LOCK: nxt_rdata[0] = lock_ff;
        default: nxt_rdata = tswdt_pkg::DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_ff <= tswdt_pkg::DATA_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence s_zero_load;
    wr_load && run_ff && (wdata == tswdt_pkg::DATA_ZERO);
  endsequence

  sequence s_quiet;
    !wr_en [*2];
  endsequence

  sequence s_second_hit;
    second_ev && rsten_ff;
  endsequence

  sequence s_locked_cfg;
    lock_ff && wr_en && ((addr == tswdt_pkg::ADDR_LOAD) || (addr == tswdt_pkg::ADDR_MASK));
  endsequence

  a_count_down: assert property (
    run_ff && (cnt_ff != '0) && !wr_en |=> cnt_ff == $past(cnt_ff) - 1'b1)
    else $error("counter did not step down");

  a_first_irq: assert property (
    first_ev && !nmisel_ff && mask_ff[tswdt_pkg::ST_FIRST] && !wr_en
      |=> irq)
    else $error("first timeout raised no interrupt");

  a_irq_gated: assert property (
    !run_ff |-> !irq && !nmi)
    else $error("interrupt while counter disabled");

  a_reload: assert property (
    tmo_ev && !wr_en |=> cnt_ff == $past(load_ff))
    else $error("no reload after timeout");

  a_reset_out: assert property (
    s_second_hit |=> sys_rst_out [*2])
    else $error("reset output not asserted and held");

  a_clear_reload: assert property (
    clr_first && run_ff && !tmo_ev |=> cnt_ff == $past(load_ff))
    else $error("clear did not reload counter");

  a_load_write: assert property (
    wr_load && run_ff |=> cnt_ff == $past(wdata[CNT_W-1:0]))
    else $error("load write not taken by counter");

  a_lock_block: assert property (
    lock_ff && wr_en && (addr == tswdt_pkg::ADDR_CTRL)
      |=> $stable(run_ff) && $stable(rsten_ff) && $stable(nmisel_ff))
    else $error("locked control changed");

  a_irq_clear: assert property (
    clr_first && !tmo_ev && !stat[tswdt_pkg::ST_SECOND]
      ##1 s_quiet |-> !irq && !nmi)
    else $error("interrupt stayed after clear");

  a_zero_load: assert property (
    s_zero_load |-> ##2 stat[tswdt_pkg::ST_FIRST])
    else $error("zero load gave no interrupt");

  a_lock_read: assert property (
    rd_en && (addr == tswdt_pkg::ADDR_LOCK) |=> rdata[0] == $past(lock_ff))
    else $error("lock state misread");

  a_enable_load: assert property (
    en_start |=> (cnt_ff == $past(load_ff)) && run_ff)
    else $error("enable did not load counter");

  a_stopped_hold: assert property (
    !run_ff && !en_start |=> $stable(cnt_ff))
    else $error("stopped counter moved");

  a_first_no_rst: assert property (
    first_ev && !sys_rst_out |=> !sys_rst_out)
    else $error("reset output on first timeout");

  a_rst_disabled: assert property (
    second_ev && !rsten_ff && !sys_rst_out |=> !sys_rst_out)
    else $error("reset output while reset disabled");

  a_rst_hold: assert property (
    sys_rst_out |=> sys_rst_out)
    else $error("reset output dropped");

  a_second_flag: assert property (
    second_ev |=> stat[tswdt_pkg::ST_SECOND])
    else $error("second timeout not flagged");

  a_stat_clear: assert property (
    wr_stat && wdata[tswdt_pkg::ST_SECOND] && !second_ev |=> !stat[tswdt_pkg::ST_SECOND])
    else $error("second flag not cleared");

  a_set_wins: assert property (
    first_ev && wr_stat && wdata[tswdt_pkg::ST_FIRST] |=> stat[tswdt_pkg::ST_FIRST])
    else $error("clear beat a new timeout");

  a_lock_cfg: assert property (
    s_locked_cfg |=> $stable(load_ff) && $stable(mask_ff))
    else $error("locked configuration changed");

  a_lock_set: assert property (
    wr_lock && (wdata != tswdt_pkg::UNLOCK_KEY) |=> lock_ff)
    else $error("lock write did not lock");

  a_unlock_key: assert property (
    wr_lock && (wdata == tswdt_pkg::UNLOCK_KEY) |=> !lock_ff)
    else $error("key did not unlock");

  a_value_read: assert property (
    rd_en && (addr == tswdt_pkg::ADDR_VALUE) |=> rdata[CNT_W-1:0] == $past(cnt_ff))
    else $error("counter value misread");

  a_stat_read: assert property (
    rd_en && (addr == tswdt_pkg::ADDR_STAT) |=> rdata[tswdt_pkg::STAT_W-1:0] == $past(stat))
    else $error("raw status misread");

  a_rdata_idle: assert property (
    !rd_en |=> rdata == tswdt_pkg::DATA_ZERO)
    else $error("read data outside read cycle");
endmodule : tswdt_top
`default_nettype wire

/* verification/test_two_stage_watchdog_timer.sv */
// Purpose: Self-checking bench for the two-stage watchdog timer.
// Assumes: Register map and timing of the watchdog package.
// Notes: Each scenario starts from a fresh reset.
`timescale 1ns/100ps
`default_nettype none
module test_two_stage_watchdog_timer;
  // ------------------------------------------------------------
  // Signals and design instance
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic nmi;
  logic sys_rst_out;
  logic [31:0] d;
  int err_total = 0;
  int cmp_count = 0;

  tswdt_top i_dut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .irq(irq), .nmi(nmi), .sys_rst_out(sys_rst_out));

  initial begin
    forever #2.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset();
    srst <= 1'b1;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // Waits for irq (0), nmi (1) or the reset output (2) to reach a level.
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    logic s;
    #1;
    for (int i = 0; i <= lim; i++) begin
      s = (sel == 0) ? irq : ((sel == 1) ? nmi : sys_rst_out);
      if (s === lvl) return;
      @(posedge clock);
      #1;
    end
    err_total++;
    $display("unexpected wait %0d: expected %h, seen %h", sel, lvl, s);
    print_verdict();
  endtask : wait_for

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    do_reset();
    rd(tswdt_pkg::ADDR_LOAD, d);
    check("load", d, 32'hFFFF_FFFF);
    rd(tswdt_pkg::ADDR_VALUE, d);
    check("value", d, 32'hFFFF_FFFF);
    rd(tswdt_pkg::ADDR_MASK, d);
    check("mask", d, 32'h0000_0003);
    rd(tswdt_pkg::ADDR_LOCK, d);
    check("lock", d & 32'h0000_0001, 32'h0000_0000);
    rd(8'h1C, d);
    check("unmapped", d, 32'h0000_0000);
    @(posedge clock);
    #1;
    check("rdata idle", rdata, 32'h0000_0000);
    check("irq idle", {31'h0000_0000, irq}, 32'h0000_0000);
  endtask : s_reset

  task automatic s_two_stage();
    do_reset();
    wr(tswdt_pkg::ADDR_LOAD, 32'h0000_0008);
    wr(tswdt_pkg::ADDR_CTRL, 32'h0000_0003);
    wait_for(0, 1'b1, 12);
    rd(tswdt_pkg::ADDR_STAT, d);
    check("first stat", d, 32'h0000_0001);
    check("early reset", {31'h0000_0000, sys_rst_out}, 32'h0000_0000);
    check("nmi off", {31'h0000_0000, nmi}, 32'h0000_0000);
    wait_for(2, 1'b1, 12);
    rd(tswdt_pkg::ADDR_STAT, d);
    check("second stat", d, 32'h0000_0003);
    wr(tswdt_pkg::ADDR_STAT, 32'h0000_0003);
    rd(tswdt_pkg::ADDR_STAT, d);
    check("both cleared", d, 32'h0000_0000);
    check("reset held", {31'h0000_0000, sys_rst_out}, 32'h0000_0001);
  endtask : s_two_stage

  task automatic s_clear();
    do_reset();
    wr(tswdt_pkg::ADDR_LOAD, 32'h0000_0014);
    wr(tswdt_pkg::ADDR_CTRL, 32'h0000_0003);
    wait_for(0, 1'b1, 24);
    rd(tswdt_pkg::ADDR_STAT, d);
    check("raw stat", d, 32'h0000_0001);
    rd(tswdt_pkg::ADDR_MSTAT, d);
    check("masked stat", d, 32'h0000_0001);
    wr(tswdt_pkg::ADDR_STAT, 32'h0000_0001);
    rd(tswdt_pkg::ADDR_STAT, d);
    check("cleared stat", d, 32'h0000_0000);
    check("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
    rd(tswdt_pkg::ADDR_VALUE, d);
    check("reload", d, 32'h0000_0011);
    wait_for(0, 1'b1, 24);
    rd(tswdt_pkg::ADDR_STAT, d);
    check("again first", d, 32'h0000_0001);
    check("no reset", {31'h0000_0000, sys_rst_out}, 32'h0000_0000);
  endtask : s_clear

  task automatic s_load();
    do_reset();
    wr(tswdt_pkg::ADDR_LOAD, 32'h0000_03E8);
    wr(tswdt_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(tswdt_pkg::ADDR_LOAD, 32'h0000_0040);
    rd(tswdt_pkg::ADDR_VALUE, d);
    check("live load", d, 32'h0000_003F);
    wr(tswdt_pkg::ADDR_LOAD, 32'h0000_0000);
    wait_for(0, 1'b1, 4);
    wr(tswdt_pkg::ADDR_MASK, 32'h0000_0000);
    rd(tswdt_pkg::ADDR_MSTAT, d);
    check("masked off", d, 32'h0000_0000);
    check("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
    rd(tswdt_pkg::ADDR_STAT, d);
    check("raw kept", d & 32'h0000_0001, 32'h0000_0001);
    check("reset disabled", {31'h0000_0000, sys_rst_out}, 32'h0000_0000);
    wr(tswdt_pkg::ADDR_MASK, 32'h0000_0003);
    wr(tswdt_pkg::ADDR_CTRL, 32'h0000_0005);
    wait_for(1, 1'b1, 4);
    check("irq in nmi mode", {31'h0000_0000, irq}, 32'h0000_0000);
  endtask : s_load

  task automatic s_lock();
    do_reset();
    wr(tswdt_pkg::ADDR_LOCK, 32'h0000_0000);
    rd(tswdt_pkg::ADDR_LOCK, d);
    check("locked", d & 32'h0000_0001, 32'h0000_0001);
    wr(tswdt_pkg::ADDR_LOAD, 32'h0000_0007);
    wr(tswdt_pkg::ADDR_CTRL, 32'h0000_0001);
    rd(tswdt_pkg::ADDR_LOAD, d);
    check("load kept", d, 32'hFFFF_FFFF);
    rd(tswdt_pkg::ADDR_VALUE, d);
    check("not running", d, 32'hFFFF_FFFF);
    check("irq locked", {31'h0000_0000, irq}, 32'h0000_0000);
    wr(tswdt_pkg::ADDR_LOCK, tswdt_pkg::UNLOCK_KEY);
    rd(tswdt_pkg::ADDR_LOCK, d);
    check("unlocked", d & 32'h0000_0001, 32'h0000_0000);
    wr(tswdt_pkg::ADDR_LOAD, 32'h0000_0007);
    rd(tswdt_pkg::ADDR_LOAD, d);
    check("load open", d, 32'h0000_0007);
  endtask : s_lock

  initial begin
    s_reset();
    s_two_stage();
    s_clear();
    s_load();
    s_lock();
    print_verdict();
  end
endmodule : test_two_stage_watchdog_timer
`default_nettype wire
